/* File: design/rim_pkg.sv */
package rim_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int RIM_SLOTS   = 16;
    localparam int RIM_SEL_W   = 8;
    localparam int RIM_DIR_N   = 8;
    localparam int RIM_FUNC_N  = 32;
    localparam int RIM_STAT_N  = 32;

    typedef logic [RIM_SEL_W-1:0] rim_sel_t;

    // ------------------------------------------------------------
    // input function codes (0 = unassigned)
    // ------------------------------------------------------------
    localparam rim_sel_t RIM_FN_NONE        = 8'h00;
    localparam rim_sel_t RIM_FN_OP_SEL0     = 8'h01;
    localparam rim_sel_t RIM_FN_OP_SEL1     = 8'h02;
    localparam rim_sel_t RIM_FN_OP_SEL2     = 8'h03;
    localparam rim_sel_t RIM_FN_START       = 8'h04;
    localparam rim_sel_t RIM_FN_RET_ORIGIN  = 8'h05;
    localparam rim_sel_t RIM_FN_HALT        = 8'h06;
    localparam rim_sel_t RIM_FN_EXC_RELEASE = 8'h07;
    localparam rim_sel_t RIM_FN_ALARM_CLEAR = 8'h08;
    localparam rim_sel_t RIM_FN_DATA_SEL0   = 8'h09;
    localparam rim_sel_t RIM_FN_DATA_SEL1   = 8'h0a;
    localparam rim_sel_t RIM_FN_DATA_SEL2   = 8'h0b;
    localparam rim_sel_t RIM_FN_SEQ_START   = 8'h0c;
    localparam rim_sel_t RIM_FN_FWD_JOG     = 8'h0d;
    localparam rim_sel_t RIM_FN_REV_JOG     = 8'h0e;
    localparam rim_sel_t RIM_FN_FWD_POS     = 8'h0f;
    localparam rim_sel_t RIM_FN_REV_POS     = 8'h10;
    localparam rim_sel_t RIM_FN_CURRENT_ON  = 8'h11;
    localparam rim_sel_t RIM_FN_OPIF_EN     = 8'h12;
    localparam rim_sel_t RIM_FN_PULSE_ONLY  = 8'h1f;

    // ------------------------------------------------------------
    // output status codes (0 = unassigned, reads 0)
    // ------------------------------------------------------------
    localparam rim_sel_t RIM_ST_NONE        = 8'h00;
    localparam rim_sel_t RIM_ST_OP_ECHO0    = 8'h01;
    localparam rim_sel_t RIM_ST_OP_ECHO1    = 8'h02;
    localparam rim_sel_t RIM_ST_OP_ECHO2    = 8'h03;
    localparam rim_sel_t RIM_ST_START_ECHO  = 8'h04;
    localparam rim_sel_t RIM_ST_HOME_DONE   = 8'h05;
    localparam rim_sel_t RIM_ST_READY       = 8'h06;
    localparam rim_sel_t RIM_ST_INFO        = 8'h07;
    localparam rim_sel_t RIM_ST_ALARM_HI    = 8'h08;
    localparam rim_sel_t RIM_ST_SYS_BUSY    = 8'h09;
    localparam rim_sel_t RIM_ST_ZONE0       = 8'h0a;
    localparam rim_sel_t RIM_ST_ZONE1       = 8'h0b;
    localparam rim_sel_t RIM_ST_ZONE2       = 8'h0c;
    localparam rim_sel_t RIM_ST_TIMING      = 8'h0d;
    localparam rim_sel_t RIM_ST_MOVING      = 8'h0e;
    localparam rim_sel_t RIM_ST_IN_POS      = 8'h0f;
    localparam rim_sel_t RIM_ST_TORQUE_LIM  = 8'h10;

    // ------------------------------------------------------------
    // group action modes
    // ------------------------------------------------------------
    localparam logic [1:0] RIM_GRP_SHAFT_ID = 2'h0;
    localparam logic [1:0] RIM_GRP_GROUP    = 2'h1;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] RIM_OFS_IN_SEL   = 12'h000; // 16 words
    localparam logic [11:0] RIM_OFS_OUT_SEL  = 12'h040; // 16 words
    localparam logic [11:0] RIM_OFS_GRP_MODE = 12'h080; // 16 words
    localparam logic [11:0] RIM_OFS_RIN      = 12'h0c0;
    localparam logic [11:0] RIM_OFS_ROUT     = 12'h0c4;
    localparam logic [11:0] RIM_OFS_DIR_SEL  = 12'h100; // 8 words
    localparam logic [11:0] RIM_OFS_FUNC     = 12'h120;
    localparam logic [11:0] RIM_OFS_STATUS   = 12'h124;
    localparam logic [11:0] RIM_OFS_REJECT   = 12'h128;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam rim_sel_t RIM_IN_RST [RIM_SLOTS] = '{
        RIM_FN_OP_SEL0, RIM_FN_OP_SEL1, RIM_FN_OP_SEL2, RIM_FN_START,
        RIM_FN_RET_ORIGIN, RIM_FN_HALT, RIM_FN_EXC_RELEASE, RIM_FN_ALARM_CLEAR,
        RIM_FN_DATA_SEL0, RIM_FN_DATA_SEL1, RIM_FN_DATA_SEL2, RIM_FN_SEQ_START,
        RIM_FN_FWD_JOG, RIM_FN_REV_JOG, RIM_FN_FWD_POS, RIM_FN_REV_POS};
    localparam rim_sel_t RIM_OUT_RST [RIM_SLOTS] = '{
        RIM_ST_OP_ECHO0, RIM_ST_OP_ECHO1, RIM_ST_OP_ECHO2, RIM_ST_START_ECHO,
        RIM_ST_HOME_DONE, RIM_ST_READY, RIM_ST_INFO, RIM_ST_ALARM_HI,
        RIM_ST_SYS_BUSY, RIM_ST_ZONE0, RIM_ST_ZONE1, RIM_ST_ZONE2,
        RIM_ST_TIMING, RIM_ST_MOVING, RIM_ST_IN_POS, RIM_ST_TORQUE_LIM};
    localparam rim_sel_t RIM_DIR_RST [RIM_DIR_N] = '{
        RIM_FN_PULSE_ONLY, RIM_FN_PULSE_ONLY, RIM_FN_RET_ORIGIN,
        RIM_FN_EXC_RELEASE, RIM_FN_HALT, RIM_FN_ALARM_CLEAR,
        RIM_FN_FWD_JOG, RIM_FN_REV_JOG};

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rim_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rim_apb_rsp_s;

    typedef struct packed {
        logic motor_excite;
        logic brake_release;
    } rim_drive_s;

endpackage

/* File: design/rim_in_combine.sv */
`timescale 1ns/1ps
module rim_in_combine
    import rim_pkg::*;
#(
    parameter int N_REM = RIM_SLOTS,
    parameter int N_DIR = RIM_DIR_N
) (
    input  wire rim_sel_t         rem_sel [N_REM], // remote slot functions
    input  wire logic [N_REM-1:0] rem_in,          // remote slot levels
    input  wire rim_sel_t         dir_sel [N_DIR], // direct terminal functions
    input  wire logic [N_DIR-1:0] dir_in,          // direct terminal levels
    output logic [RIM_FUNC_N-1:0] func             // combined function levels
);

    // ------------------------------------------------------------
    // per-function combining
    // ------------------------------------------------------------
    logic [RIM_FUNC_N-1:0] rem_any, rem_asg, dir_any, dir_asg;

    always_comb begin
        rem_any = '0;
        rem_asg = '0;
        dir_any = '0;
        dir_asg = '0;
        for (int i = 0; i < N_REM; i++) begin
            if (rem_sel[i] != RIM_FN_NONE && rem_sel[i] < RIM_FUNC_N) begin
                rem_asg[rem_sel[i][4:0]] = 1'b1;
                rem_any[rem_sel[i][4:0]] = rem_any[rem_sel[i][4:0]] | rem_in[i];
            end
        end
        for (int j = 0; j < N_DIR; j++) begin
            if (dir_sel[j] != RIM_FN_NONE && dir_sel[j] < RIM_FUNC_N) begin
                dir_asg[dir_sel[j][4:0]] = 1'b1;
                dir_any[dir_sel[j][4:0]] = dir_any[dir_sel[j][4:0]] | dir_in[j];
            end
        end
        func = rem_any | dir_any;
        func[RIM_FN_NONE[4:0]]      = 1'b0;
        func[RIM_FN_PULSE_ONLY[4:0]] = 1'b0;
        // enable-type functions: default on, direct and remote ANDed
        for (int k = 0; k < 2; k++) begin
            automatic int f = (k == 0) ? int'(RIM_FN_CURRENT_ON) : int'(RIM_FN_OPIF_EN);
            func[f] = (!dir_asg[f] || dir_any[f]) && (!rem_asg[f] || rem_any[f]);
        end
    end

endmodule // rim_in_combine

/* File: design/rim_out_select.sv */
`timescale 1ns/1ps
module rim_out_select
    import rim_pkg::*;
#(
    parameter int N_REM = RIM_SLOTS
) (
    input  wire logic                  pclk,            // clock
    input  wire logic                  presetn,         // async reset, low
    input  wire rim_sel_t              out_sel [N_REM], // slot status choice
    input  wire logic [RIM_STAT_N-1:0] status,          // internal status
    output logic [N_REM-1:0]           rem_out          // remote output word
);

    logic [N_REM-1:0] rem_out_d;

    always_comb begin
        for (int i = 0; i < N_REM; i++) begin
            if (out_sel[i] == RIM_ST_NONE || out_sel[i] >= RIM_STAT_N) begin
                rem_out_d[i] = 1'b0;
            end else begin
                rem_out_d[i] = status[out_sel[i][4:0]];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_out <= '0;
        end else begin
            rem_out <= rem_out_d;
        end
    end

endmodule // rim_out_select

/* File: design/rim_mapper.sv */
`timescale 1ns/1ps

// Behaviour
// - remote slots travel only through the apb rin and rout registers, apart from direct terminals.
// - sixteen remote input slots each drive a function picked by a selector.
// - input slots 0..7 reset to op select 0..2, start, origin, halt, release, alarm clear.
// - input slots 8..15 reset to data select 0..2, seq start, jogs and position moves.
// - sixteen remote output slots each report a status picked by a selector.
// - output slots 0..7 reset to op echoes 0..2, start echo, home, ready, info, alarm.
// - output slots 8..15 reset to busy, zones 0..2, timing, moving, in-position, torque.
// - apart from the two enables, a function fed by several sources is the OR of them.
// - unassigned current-on and operator enables are held active.
// - those enables assigned both direct and remote are the AND of both.
// - pulse input terminals refuse any other function.
// - each input slot has a group action mode, reset to per-shaft identifier.
// - current-on active excites the motor, inactive stops excitation.
// - excitation release cuts current and frees the brake.
module rim_mapper
    import rim_pkg::*;
#(
    parameter int N_REM = RIM_SLOTS,
    parameter int N_DIR = RIM_DIR_N
) (
    input  wire logic                  pclk,       // clock
    input  wire logic                  presetn,    // async reset, low
    input  wire logic                  psel,       // apb select
    input  wire logic                  penable,    // apb enable
    input  wire logic                  pwrite,     // apb direction
    input  wire logic [11:0]           paddr,      // apb byte address
    input  wire logic [31:0]           pwdata,     // apb write data
    output logic [31:0]                prdata,     // apb read data
    output logic                       pready,     // apb ready
    output logic                       pslverr,    // apb error
    input  wire logic                  pulse_var,  // pulse-input variant
    input  wire logic [N_DIR-1:0]      dir_in,     // direct terminal levels
    input  wire logic [RIM_STAT_N-1:0] status,     // internal status flags
    output logic [RIM_FUNC_N-1:0]      func,       // internal function levels
    output rim_drive_s                 drive       // excitation and brake
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rim_sel_t         in_sel_q  [N_REM];
    rim_sel_t         in_sel_d  [N_REM];
    rim_sel_t         out_sel_q [N_REM];
    rim_sel_t         out_sel_d [N_REM];
    rim_sel_t         dir_sel_q [N_DIR];
    rim_sel_t         dir_sel_d [N_DIR];
    logic [1:0]       grp_q     [N_REM];
    logic [1:0]       grp_d     [N_REM];
    logic [N_REM-1:0] rin_q, rin_d;
    logic             reject_q, reject_d;
    logic [31:0]      rdata_q, rdata_d;
    rim_drive_s       drive_q, drive_d;
    logic [N_REM-1:0] rem_out;
    logic [RIM_FUNC_N-1:0] func_c;

    logic        acc, wr, rd, hit;
    logic [11:0] a;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_block(input logic [11:0] ad, input logic [11:0] base,
                                      input int n);
        return ad >= base && ad < base + 12'(4 * n);
    endfunction

    function automatic int idx(input logic [11:0] ad, input logic [11:0] base);
        return int'((ad - base) >> 2);
    endfunction

    // pulse terminals are the first two direct terminals
    function automatic logic pulse_term(input int t);
        return t < 2;
    endfunction

    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    assign a      = {paddr[11:2], 2'b00};
    assign pready = 1'b1;

    always_comb begin
        hit = in_block(a, RIM_OFS_IN_SEL, N_REM) || in_block(a, RIM_OFS_OUT_SEL, N_REM)
           || in_block(a, RIM_OFS_GRP_MODE, N_REM) || in_block(a, RIM_OFS_DIR_SEL, N_DIR)
           || a == RIM_OFS_RIN || a == RIM_OFS_ROUT || a == RIM_OFS_FUNC
           || a == RIM_OFS_STATUS || a == RIM_OFS_REJECT;
    end

    assign pslverr = acc && !hit;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_comb begin
        in_sel_d  = in_sel_q;
        out_sel_d = out_sel_q;
        dir_sel_d = dir_sel_q;
        grp_d     = grp_q;
        rin_d     = rin_q;
        reject_d  = reject_q;
        if (wr) begin
            if (in_block(a, RIM_OFS_IN_SEL, N_REM)) begin
                in_sel_d[idx(a, RIM_OFS_IN_SEL)] = pwdata[RIM_SEL_W-1:0];
            end
            if (in_block(a, RIM_OFS_OUT_SEL, N_REM)) begin
                out_sel_d[idx(a, RIM_OFS_OUT_SEL)] = pwdata[RIM_SEL_W-1:0];
            end
            if (in_block(a, RIM_OFS_GRP_MODE, N_REM)) begin
                grp_d[idx(a, RIM_OFS_GRP_MODE)] = pwdata[1:0];
            end
            if (in_block(a, RIM_OFS_DIR_SEL, N_DIR)) begin
                if (pulse_var && pulse_term(idx(a, RIM_OFS_DIR_SEL))) begin
                    reject_d = 1'b1;
                end else begin
                    dir_sel_d[idx(a, RIM_OFS_DIR_SEL)] = pwdata[RIM_SEL_W-1:0];
                end
            end
            if (a == RIM_OFS_RIN) begin
                rin_d = pwdata[N_REM-1:0];
            end
            if (a == RIM_OFS_REJECT && pwdata[0]) begin
                reject_d = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // readback and drive
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (rd) begin
            rdata_d = '0;
            if (in_block(a, RIM_OFS_IN_SEL, N_REM)) begin
                rdata_d[RIM_SEL_W-1:0] = in_sel_q[idx(a, RIM_OFS_IN_SEL)];
            end
            if (in_block(a, RIM_OFS_OUT_SEL, N_REM)) begin
                rdata_d[RIM_SEL_W-1:0] = out_sel_q[idx(a, RIM_OFS_OUT_SEL)];
            end
            if (in_block(a, RIM_OFS_GRP_MODE, N_REM)) begin
                rdata_d[1:0] = grp_q[idx(a, RIM_OFS_GRP_MODE)];
            end
            if (in_block(a, RIM_OFS_DIR_SEL, N_DIR)) begin
                rdata_d[RIM_SEL_W-1:0] = dir_sel_q[idx(a, RIM_OFS_DIR_SEL)];
            end
            if (a == RIM_OFS_RIN)    rdata_d[N_REM-1:0] = rin_q;
            if (a == RIM_OFS_ROUT)   rdata_d[N_REM-1:0] = rem_out;
            if (a == RIM_OFS_FUNC)   rdata_d = func_c;
            if (a == RIM_OFS_STATUS) rdata_d = status;
            if (a == RIM_OFS_REJECT) rdata_d[0] = reject_q;
        end
    end

    always_comb begin
        drive_d.motor_excite  = func_c[RIM_FN_CURRENT_ON[4:0]]
                             && !func_c[RIM_FN_EXC_RELEASE[4:0]];
        drive_d.brake_release = func_c[RIM_FN_EXC_RELEASE[4:0]]
                             || func_c[RIM_FN_CURRENT_ON[4:0]];
    end

    // read data is combinational of the access cycle
    assign prdata = rd ? rdata_d : 32'h0000_0000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N_REM; i++) begin
                in_sel_q[i]  <= RIM_IN_RST[i];
                out_sel_q[i] <= RIM_OUT_RST[i];
                grp_q[i]     <= RIM_GRP_SHAFT_ID;
            end
            for (int j = 0; j < N_DIR; j++) begin
                dir_sel_q[j] <= RIM_DIR_RST[j];
            end
            rin_q    <= '0;
            reject_q <= 1'b0;
            rdata_q  <= '0;
            drive_q  <= '0;
            func     <= '0;
        end else begin
            in_sel_q  <= in_sel_d;
            out_sel_q <= out_sel_d;
            dir_sel_q <= dir_sel_d;
            grp_q     <= grp_d;
            rin_q     <= rin_d;
            reject_q  <= reject_d;
            rdata_q   <= rdata_d;
            drive_q   <= drive_d;
            func      <= func_c;
        end
    end

    assign drive = drive_q;

    // ------------------------------------------------------------
    // mapping
    // ------------------------------------------------------------
    rim_in_combine #(
        .N_REM (N_REM),
        .N_DIR (N_DIR)
    ) u_in (
        .rem_sel (in_sel_q),
        .rem_in  (rin_q),
        .dir_sel (dir_sel_q),
        .dir_in  (dir_in),
        .func    (func_c)
    );

    rim_out_select #(
        .N_REM (N_REM)
    ) u_out (
        .pclk    (pclk),
        .presetn (presetn),
        .out_sel (out_sel_q),
        .status  (status),
        .rem_out (rem_out)
    );

endmodule // rim_mapper

/* File: verif/rim_mapper_props.sv */
`timescale 1ns/1ps
module rim_mapper_props
    import rim_pkg::*;
(
    input wire logic                  pclk,    // clock
    input wire logic                  presetn, // async reset, low
    input wire logic                  psel,    // apb select
    input wire logic                  penable, // apb enable
    input wire logic                  pwrite,  // apb direction
    input wire logic [11:0]           paddr,   // apb address
    input wire logic [31:0]           prdata,  // apb read data
    input wire logic                  pready,  // apb ready
    input wire logic                  pslverr, // apb error
    input wire logic [RIM_FUNC_N-1:0] func,    // function levels
    input wire rim_drive_s            drive    // excitation, brake
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    property p_rdy;
        pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    property p_err_acc;
        pslverr |-> psel && penable;
    endproperty
    a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
    property p_rd_idle;
        !(psel && penable && !pwrite) |-> prdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero");
    property p_unmap;
        psel && penable && paddr[11:2] > 10'h04a |-> pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_mapped;
        psel && penable && paddr < 12'h0c8 && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    // ------------------------------------------------------------
    // function levels and drive
    // ------------------------------------------------------------
    property p_none;
        func[0] == 1'b0;
    endproperty
    a_none: assert property (p_none) else $error("code zero active");
    property p_en_rst;
        $rose(presetn) |-> ##[0:2] (func[RIM_FN_CURRENT_ON] && func[RIM_FN_OPIF_EN]);
    endproperty
    a_en_rst: assert property (p_en_rst) else $error("enables not active");
    property p_excite;
        drive.motor_excite == (func[RIM_FN_CURRENT_ON] && !func[RIM_FN_EXC_RELEASE]);
    endproperty
    a_excite: assert property (p_excite) else $error("excite mismatch");
    property p_brake;
        drive.brake_release == (func[RIM_FN_CURRENT_ON] || func[RIM_FN_EXC_RELEASE]);
    endproperty
    a_brake: assert property (p_brake) else $error("brake mismatch");

    c_wr: cover property (psel && penable && pwrite);
    c_err: cover property (pslverr);
    c_exc_off: cover property ($fell(drive.motor_excite));
endmodule // rim_mapper_props

/* File: verif/rim_host.sv */
`timescale 1ns/1ps
module rim_host (
    input  wire logic        pclk,    // clock
    output logic             psel,    // apb select
    output logic             penable, // apb enable
    output logic             pwrite,  // apb direction
    output logic [11:0]      paddr,   // apb address
    output logic [31:0]      pwdata,  // apb write data
    input  wire logic [31:0] prdata,  // apb read data
    input  wire logic        pready,  // apb ready
    input  wire logic        pslverr  // apb error
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end

    // one transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // rim_host

/* File: verif/rim_mapper_tb.sv */
`timescale 1ns/1ps
module rim_mapper_tb
    import rim_pkg::*;
;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  pulse_var;
    logic [RIM_DIR_N-1:0]  dir_in;
    logic [RIM_STAT_N-1:0] status;
    logic [RIM_FUNC_N-1:0] func;
    rim_drive_s            drive;
    logic [31:0]           rv;
    logic                  e;
    int                    err_count;
    int                    comparisons;
    int                    cyc;

    rim_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_var(pulse_var), .dir_in(dir_in), .status(status),
        .func(func), .drive(drive));
    rim_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #25 pclk = ~pclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        host.xfer(1'b1, a, d, r, x);
    endtask
    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0, rv, e);
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wt;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish;
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        pulse_var = 1'b0;
        dir_in = '0;
        status = '0;
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        wt;
        chk("enables", 32'h3, {func[RIM_FN_OPIF_EN], func[RIM_FN_CURRENT_ON]});
        chk("excite", 32'h1, drive.motor_excite);
        for (int i = 0; i < RIM_SLOTS; i++) begin
            rd(RIM_OFS_IN_SEL + 12'(4 * i));
            chk("in_sel", RIM_IN_RST[i], rv);
            rd(RIM_OFS_OUT_SEL + 12'(4 * i));
            chk("out_sel", RIM_OUT_RST[i], rv);
            rd(RIM_OFS_GRP_MODE + 12'(4 * i));
            chk("grp_mode", RIM_GRP_SHAFT_ID, rv);
        end
        wr(RIM_OFS_GRP_MODE, RIM_GRP_GROUP);
        rd(RIM_OFS_GRP_MODE);
        chk("grp_mode", RIM_GRP_GROUP, rv);
        // remote slot, default slot and direct terminal on one function
        wr(RIM_OFS_IN_SEL, RIM_FN_FWD_JOG);
        for (int k = 0; k < 4; k++) begin
            wr(RIM_OFS_RIN, k == 0 ? 32'h1 : k == 1 ? 32'h1000 : 32'h0);
            @(posedge pclk);
            dir_in <= k == 2 ? 8'h40 : 8'h00;
            wt;
            chk("or_fn", k < 3, func[RIM_FN_FWD_JOG]);
        end
        wr(RIM_OFS_IN_SEL + 12'h4, RIM_FN_NONE);
        wr(RIM_OFS_RIN, 32'h2);
        wt;
        chk("none_slot", 32'h0, func[RIM_FN_OP_SEL1]);
        // enable from both sides
        wr(RIM_OFS_IN_SEL + 12'h8, RIM_FN_CURRENT_ON);
        wr(RIM_OFS_DIR_SEL + 12'h8, RIM_FN_CURRENT_ON);
        for (int k = 0; k < 4; k++) begin
            wr(RIM_OFS_RIN, {29'h0, k[0], 2'h0});
            @(posedge pclk);
            dir_in <= {5'h0, k[1], 2'h0};
            wt;
            chk("c_on", k == 3, func[RIM_FN_CURRENT_ON]);
            chk("excite", k == 3, drive.motor_excite);
        end
        wr(RIM_OFS_RIN, 32'h44);
        wt;
        chk("brake", 32'h1, drive.brake_release);
        chk("excite", 32'h0, drive.motor_excite);
        // pulse terminals locked on pulse variant
        @(posedge pclk);
        pulse_var <= 1'b1;
        wr(RIM_OFS_DIR_SEL, RIM_FN_HALT);
        rd(RIM_OFS_DIR_SEL);
        chk("dir0", RIM_FN_PULSE_ONLY, rv);
        rd(RIM_OFS_REJECT);
        chk("reject", 32'h1, rv & 32'h1);
        wr(RIM_OFS_REJECT, 32'h1);
        rd(RIM_OFS_REJECT);
        chk("reject", 32'h0, rv & 32'h1);
        @(posedge pclk);
        pulse_var <= 1'b0;
        wr(RIM_OFS_DIR_SEL, RIM_FN_HALT);
        rd(RIM_OFS_DIR_SEL);
        chk("dir0", RIM_FN_HALT, rv);
        // output word
        @(posedge pclk);
        status <= 32'h0001_5554;
        wt;
        rd(RIM_OFS_ROUT);
        chk("rout", 32'h0000_aaaa, rv);
        wr(RIM_OFS_OUT_SEL + 12'hc, RIM_ST_NONE);
        wr(RIM_OFS_OUT_SEL, RIM_ST_TORQUE_LIM);
        wt;
        rd(RIM_OFS_ROUT);
        chk("rout", 32'h0000_aaa3, rv);
        rd(RIM_OFS_FUNC);
        chk("func_rd", 32'h0006_0080, rv);
        rd(RIM_OFS_STATUS);
        chk("status_rd", 32'h0001_5554, rv);
        rd(12'h200);
        chk("pslverr", 32'h1, e);
        chk("rd_unmap", 32'h0, rv);
        tally_and_finish;
    end
endmodule // rim_mapper_tb

bind rim_mapper rim_mapper_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .func(func), .drive(drive));
